// ---- udbf_pkg.sv ----
// Constants, register map and state types of the serial data buffer block.
// Assumes one 20 MHz system clock and an AXI4-Lite master for software.
package udbf_pkg;

  // ---------------------------------------------------------------------------
  // Clock and bus
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned AXI_AW   = 8;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_DATA   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CTRL_B = 8'h08;
  localparam logic [7:0] OFF_CTRL_C = 8'h0C;
  localparam logic [7:0] OFF_BAUD   = 8'h10;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned ST_PE    = 2;
  localparam int unsigned ST_DOR   = 3;
  localparam int unsigned ST_FE    = 4;
  localparam int unsigned ST_UDRE  = 5;
  localparam int unsigned ST_TXC   = 6;
  localparam int unsigned ST_RXC   = 7;
  localparam int unsigned CB_TXB8  = 0;
  localparam int unsigned CB_RXB8  = 1;
  localparam int unsigned CB_SIZE2 = 2;
  localparam int unsigned CB_TXEN  = 3;
  localparam int unsigned CB_RXEN  = 4;
  localparam int unsigned CB_UDRIE = 5;
  localparam int unsigned CB_TXCIE = 6;
  localparam int unsigned CC_POL   = 0;
  localparam int unsigned CC_SIZE0 = 1;
  localparam int unsigned CC_STOP  = 3;
  localparam int unsigned CC_PM0   = 4;
  localparam int unsigned CC_SYNC  = 6;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  SIZE_RESET = 3'h3;
  localparam logic [2:0]  SIZE_NINE  = 3'h7;
  localparam logic [15:0] BAUD_RESET = 16'h0081;
  localparam logic [3:0]  OS_MID     = 4'h7;
  localparam logic [3:0]  OS_LAST    = 4'hF;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} udbf_rx_e;

  typedef struct packed {
    logic [8:0] data;
    logic       fe;
    logic       dor;
    logic       upe;
  } udbf_rx_entry_s;

  typedef struct packed {
    logic        tx_en;
    logic        rx_en;
    logic        udrie;
    logic        txcie;
    logic        txb8;
    logic [2:0]  size;
    logic [1:0]  pm;
    logic        stop2;
    logic        sync;
    logic        pol;
    logic [15:0] baud;
  } udbf_ctrl_s;

  typedef struct packed {
    // Bus side
    logic                awready;
    logic                wready;
    logic                aw_got;
    logic [AXI_AW-1:0]   aw_addr;
    logic                w_got;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    udbf_ctrl_s          ctrl;
    // Pin sampling
    logic                rxd_s1;
    logic                rxd_s2;
    logic                sclk_s1;
    logic                sclk_s2;
    logic                sclk_prev;
    logic [15:0]         baud_cnt;
    // Transmitter
    logic [8:0]          tbuf;
    logic                tbuf_full;
    logic                tx_busy;
    logic [12:0]         tx_sh;
    logic [3:0]          tx_cnt;
    logic [3:0]          tx_phase;
    logic                txc;
    logic                txd;
    logic                txd_oe;
    logic                udre_irq;
    logic                txc_irq;
    // Receiver
    udbf_rx_e            rx_st;
    logic [3:0]          rx_phase;
    logic [3:0]          rx_idx;
    logic [10:0]         rx_sh;
    logic                ovr;
    logic                pend_valid;
    udbf_rx_entry_s      pend;
    udbf_rx_entry_s [1:0] fifo;
    logic                rd_ptr;
    logic [1:0]          count;
    logic                rx_own;
  } udbf_state_s;

endpackage : udbf_pkg

// ---- udbf_top.sv ----
// Serial port data path: buffered transmitter, two-deep receive FIFO, flags.
// Assumes an AXI4-Lite master on aclk; rxd and external_serial_clock are asynchronous pins.
// Functional notes
// - Buffer-empty flag shows transmit buffer is empty
// - Buffer-empty request held while flag set
// - Data register write clears buffer-empty flag
// - Complete flag sets after frame, buffer empty
// - Complete flag clears on service or one-write
// - Complete request when flag set and enabled
// - Parity bit inserted before first stop bit
// - Transmitter disable waits for buffer and shifter
// - Receiver enable takes over the input pin
// - Start bit begins reception, bits then sampled
// - Frame ends at first stop bit
// - Completed frame moves into receive buffer
// - Unused upper data bits read as zero
// - Ninth bit and errors travel in FIFO
// - Shifter loads when idle or after stop
// - Receive-complete flag shows unread data present
// - Two-deep buffer plus shifter, overrun on fourth start
// - Parity is xor of data, inverted odd
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module udbf_top (
  input  wire logic                       aclk,          // System clock
  input  wire logic                       aresetn,       // Sync reset, active low
  input  wire logic [udbf_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
  input  wire logic                       s_axi_awvalid, // Write address valid
  output logic                            s_axi_awready, // Write address ready
  input  wire logic [31:0]                s_axi_wdata,   // Write data
  input  wire logic [3:0]                 s_axi_wstrb,   // Write byte strobes
  input  wire logic                       s_axi_wvalid,  // Write data valid
  output logic                            s_axi_wready,  // Write data ready
  output logic [1:0]                      s_axi_bresp,   // Write response
  output logic                            s_axi_bvalid,  // Write response valid
  input  wire logic                       s_axi_bready,  // Write response ready
  input  wire logic [udbf_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
  input  wire logic                       s_axi_arvalid, // Read address valid
  output logic                            s_axi_arready, // Read address ready
  output logic [31:0]                     s_axi_rdata,   // Read data
  output logic [1:0]                      s_axi_rresp,   // Read response
  output logic                            s_axi_rvalid,  // Read data valid
  input  wire logic                       s_axi_rready,  // Read data ready
  input  wire logic                       rxd,           // Serial input pin
  input  wire logic                       external_serial_clock, // External serial clock pin
  output logic                            txd,           // Serial output
  output logic                            txd_oe,        // Transmitter owns output pin
  output logic                            rx_pin_owned,  // Receiver owns input pin
  output logic                            udre_irq_req,  // Buffer-empty request level
  output logic                            txc_irq_req,   // Transmit-complete request
  input  wire logic                       txc_irq_ack    // Complete request serviced
);

  // ---------------------------------------------------------------------------
  // Frame helpers
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] data_bits(input logic [2:0] size);
    case (size)
      3'h0:    data_bits = 4'h5;
      3'h1:    data_bits = 4'h6;
      3'h2:    data_bits = 4'h7;
      3'h7:    data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction : data_bits

  function automatic logic [8:0] data_mask(input logic [2:0] size);
    data_mask = 9'h1FF >> (4'h9 - data_bits(size));
  endfunction : data_mask

  // Start, data LSB first, optional parity, then stop bits (ones)
  function automatic logic [12:0] tx_frame(input logic [8:0]  d,
                                           input udbf_pkg::udbf_ctrl_s c);
    logic [3:0] n;
    logic [8:0] dm;
    n  = data_bits(c.size);
    dm = d & data_mask(c.size);
    tx_frame = {4'hF, dm} << 1;
    tx_frame = tx_frame | (13'h1FFF << (n + 4'h1));
    if (c.pm[1]) begin
      tx_frame[n + 4'h1] = ^dm ^ c.pm[0];
    end
  endfunction : tx_frame

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  udbf_pkg::udbf_state_s q;
  udbf_pkg::udbf_state_s d;

  always_comb begin
    logic           tick;
    logic           x_rise;
    logic           x_fall;
    logic           tx_edge;
    logic           rx_edge;
    logic           tx_bit_end;
    logic           pop;
    logic           do_wr;
    logic [3:0]     n;
    logic [3:0]     plen;
    logic           pbit;
    logic           sbit;
    logic [8:0]     rdat;
    logic [1:0]     cnt_after;
    logic           wptr;
    logic [31:0]    rd;
    udbf_pkg::udbf_rx_entry_s head;
    d          = q;
    tick       = 1'b0;
    pop        = 1'b0;
    do_wr      = 1'b0;
    rd         = 32'h0000_0000;
    n          = data_bits(q.ctrl.size);
    plen       = {3'h0, q.ctrl.pm[1]};
    pbit       = 1'b0;
    sbit       = 1'b0;
    rdat       = 9'h000;
    cnt_after  = 2'h0;
    wptr       = 1'b0;
    head       = q.fifo[q.rd_ptr];

    // -------------------------------------------------------------------------
    // Pin synchronisers and rate enables
    // -------------------------------------------------------------------------
    d.rxd_s1   = rxd;
    d.rxd_s2   = q.rxd_s1;
    d.sclk_s1   = external_serial_clock;
    d.sclk_s2   = q.sclk_s1;
    d.sclk_prev = q.sclk_s2;
    x_rise      = q.sclk_s2 & ~q.sclk_prev;
    x_fall      = ~q.sclk_s2 & q.sclk_prev;
    if (q.baud_cnt >= q.ctrl.baud) begin
      d.baud_cnt = 16'h0000;
      tick       = 1'b1;
    end else begin
      d.baud_cnt = q.baud_cnt + 16'h0001;
    end
    // Polarity 0: change on rising, sample on falling
    tx_edge = q.ctrl.pol ? x_fall : x_rise;
    rx_edge = q.ctrl.pol ? x_rise : x_fall;
    tx_bit_end = q.ctrl.sync ? tx_edge : (tick && q.tx_phase == udbf_pkg::OS_LAST);

    // -------------------------------------------------------------------------
    // Register reads; data read pops the FIFO
    // -------------------------------------------------------------------------
    if (s_axi_arvalid && q.arready) begin
      d.rresp = udbf_pkg::RESP_OK;
      case (s_axi_araddr)
        udbf_pkg::OFF_DATA: begin
          rd[7:0] = head.data[7:0] & {8{q.count != 2'h0}};
          pop     = q.count != 2'h0;
        end
        udbf_pkg::OFF_STATUS: begin
          rd[udbf_pkg::ST_RXC]  = q.count != 2'h0;
          rd[udbf_pkg::ST_TXC]  = q.txc;
          rd[udbf_pkg::ST_UDRE] = ~q.tbuf_full;
          rd[udbf_pkg::ST_FE]   = head.fe & (q.count != 2'h0);
          rd[udbf_pkg::ST_DOR]  = head.dor & (q.count != 2'h0);
          rd[udbf_pkg::ST_PE]   = head.upe & (q.count != 2'h0);
        end
        udbf_pkg::OFF_CTRL_B: begin
          rd[udbf_pkg::CB_TXB8]  = q.ctrl.txb8;
          rd[udbf_pkg::CB_RXB8]  = head.data[8] & (q.count != 2'h0);
          rd[udbf_pkg::CB_SIZE2] = q.ctrl.size[2];
          rd[udbf_pkg::CB_TXEN]  = q.ctrl.tx_en;
          rd[udbf_pkg::CB_RXEN]  = q.ctrl.rx_en;
          rd[udbf_pkg::CB_UDRIE] = q.ctrl.udrie;
          rd[udbf_pkg::CB_TXCIE] = q.ctrl.txcie;
        end
        udbf_pkg::OFF_CTRL_C: begin
          rd[udbf_pkg::CC_POL]                       = q.ctrl.pol;
          rd[udbf_pkg::CC_SIZE0 +: 2]                = q.ctrl.size[1:0];
          rd[udbf_pkg::CC_STOP]                      = q.ctrl.stop2;
          rd[udbf_pkg::CC_PM0 +: 2]                  = q.ctrl.pm;
          rd[udbf_pkg::CC_SYNC]                      = q.ctrl.sync;
        end
        udbf_pkg::OFF_BAUD: rd[15:0] = q.ctrl.baud;
        default: d.rresp = udbf_pkg::RESP_ERR;
      endcase
      d.rdata  = rd;
      d.rvalid = 1'b1;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // -------------------------------------------------------------------------
    // Register writes, taken once address and data have both arrived
    // -------------------------------------------------------------------------
    if (s_axi_awvalid && q.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      do_wr    = 1'b1;
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = udbf_pkg::RESP_OK;
      case (q.aw_addr)
        udbf_pkg::OFF_DATA: begin
          if (q.w_strb[0]) begin
            d.tbuf      = {q.ctrl.txb8, q.w_data[7:0]};
            d.tbuf_full = 1'b1;
          end
        end
        udbf_pkg::OFF_STATUS: ;
        udbf_pkg::OFF_CTRL_B: begin
          if (q.w_strb[0]) begin
            d.ctrl.txb8    = q.w_data[udbf_pkg::CB_TXB8];
            d.ctrl.size[2] = q.w_data[udbf_pkg::CB_SIZE2];
            d.ctrl.tx_en   = q.w_data[udbf_pkg::CB_TXEN];
            d.ctrl.rx_en   = q.w_data[udbf_pkg::CB_RXEN];
            d.ctrl.udrie   = q.w_data[udbf_pkg::CB_UDRIE];
            d.ctrl.txcie   = q.w_data[udbf_pkg::CB_TXCIE];
          end
        end
        udbf_pkg::OFF_CTRL_C: begin
          if (q.w_strb[0]) begin
            d.ctrl.pol       = q.w_data[udbf_pkg::CC_POL];
            d.ctrl.size[1:0] = q.w_data[udbf_pkg::CC_SIZE0 +: 2];
            d.ctrl.stop2     = q.w_data[udbf_pkg::CC_STOP];
            d.ctrl.pm        = q.w_data[udbf_pkg::CC_PM0 +: 2];
            d.ctrl.sync      = q.w_data[udbf_pkg::CC_SYNC];
          end
        end
        udbf_pkg::OFF_BAUD: begin
          if (q.w_strb[0]) d.ctrl.baud[7:0]  = q.w_data[7:0];
          if (q.w_strb[1]) d.ctrl.baud[15:8] = q.w_data[15:8];
        end
        default: d.bresp = udbf_pkg::RESP_ERR;
      endcase
    end

    // -------------------------------------------------------------------------
    // Transmitter
    // -------------------------------------------------------------------------
    if (q.tx_busy) begin
      if (!q.ctrl.sync && tick) begin
        d.tx_phase = q.tx_phase + 4'h1;
      end
      if (tx_bit_end) begin
        if (q.tx_cnt == 4'h1) begin
          d.tx_busy = 1'b0;
          if (!q.tbuf_full) begin
            d.txc = 1'b1;
          end
        end else begin
          d.tx_sh  = {1'b1, q.tx_sh[12:1]};
          d.tx_cnt = q.tx_cnt - 4'h1;
        end
      end
    end
    // Reload in the same cycle the stop bit ends, so frames run back to back
    if (q.txd_oe && q.tbuf_full && (!q.tx_busy || (tx_bit_end && q.tx_cnt == 4'h1))) begin
      d.tx_busy   = 1'b1;
      d.tx_sh     = tx_frame(q.tbuf, q.ctrl);
      d.tx_cnt    = 4'h2 + n + plen + {3'h0, q.ctrl.stop2};
      d.tx_phase  = 4'h0;
      d.tbuf_full = do_wr && q.aw_addr == udbf_pkg::OFF_DATA && q.w_strb[0];
    end
    // Hardware set wins over a clear in the same cycle
    if (!(d.txc && !q.txc)) begin
      if (txc_irq_ack || (do_wr && q.aw_addr == udbf_pkg::OFF_STATUS && q.w_strb[0] &&
          q.w_data[udbf_pkg::ST_TXC])) begin
        d.txc = 1'b0;
      end
    end
    if (q.ctrl.tx_en) begin
      d.txd_oe = 1'b1;
    end else if (!d.tx_busy && !d.tbuf_full) begin
      d.txd_oe = 1'b0;
    end
    d.txd      = d.tx_busy ? d.tx_sh[0] : 1'b1;
    d.udre_irq = q.ctrl.udrie & ~d.tbuf_full;
    d.txc_irq  = q.ctrl.txcie & d.txc;

    // -------------------------------------------------------------------------
    // Receiver
    // -------------------------------------------------------------------------
    if (pop) begin
      d.rd_ptr = ~q.rd_ptr;
      d.count  = q.count - 2'h1;
    end
    cnt_after = d.count;
    // Frame held in the shifter moves on as soon as a slot frees
    if (q.pend_valid && cnt_after != 2'h2) begin
      wptr            = d.rd_ptr ^ cnt_after[0];
      d.fifo[wptr]    = q.pend;
      d.count         = cnt_after + 2'h1;
      d.pend_valid    = 1'b0;
    end
    case (q.rx_st)
      udbf_pkg::RX_IDLE: begin
        if (q.ctrl.sync ? (rx_edge && !q.rxd_s2) : (tick && !q.rxd_s2)) begin
          d.rx_st    = q.ctrl.sync ? udbf_pkg::RX_BITS : udbf_pkg::RX_START;
          d.rx_phase = 4'h0;
          d.rx_idx   = 4'h0;
          if (q.count == 2'h2 && q.pend_valid) begin
            d.ovr = 1'b1;
          end
        end
      end
      udbf_pkg::RX_START: begin
        if (tick) begin
          d.rx_phase = q.rx_phase + 4'h1;
          if (q.rx_phase == udbf_pkg::OS_MID) begin
            d.rx_phase = 4'h0;
            d.rx_st    = q.rxd_s2 ? udbf_pkg::RX_IDLE : udbf_pkg::RX_BITS;
          end
        end
      end
      udbf_pkg::RX_BITS: begin
        if (q.ctrl.sync ? rx_edge : (tick && q.rx_phase == udbf_pkg::OS_LAST)) begin
          d.rx_sh[q.rx_idx] = q.rxd_s2;
          d.rx_idx          = q.rx_idx + 4'h1;
          // Second stop bit is never looked at
          if (q.rx_idx == n + plen) begin
            rdat          = q.rx_sh[8:0] & data_mask(q.ctrl.size);
            pbit          = q.rx_sh[n];
            sbit          = q.rxd_s2;
            d.pend.data   = rdat;
            d.pend.fe     = ~sbit;
            d.pend.dor    = q.ovr;
            d.pend.upe    = q.ctrl.pm[1] & (^rdat ^ q.ctrl.pm[0] ^ pbit);
            d.pend_valid  = 1'b1;
            d.ovr         = 1'b0;
            d.rx_st       = udbf_pkg::RX_IDLE;
          end
        end
        if (!q.ctrl.sync && tick) begin
          d.rx_phase = q.rx_phase + 4'h1;
        end
      end
      default: d.rx_st = udbf_pkg::RX_IDLE;
    endcase
    // Disabling the receiver is immediate and flushes everything
    if (!q.ctrl.rx_en) begin
      d.rx_st      = udbf_pkg::RX_IDLE;
      d.count      = 2'h0;
      d.pend_valid = 1'b0;
      d.ovr        = 1'b0;
    end
    d.rx_own = d.ctrl.rx_en;

    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready  = ~d.w_got & ~d.bvalid;
    d.arready = ~d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.ctrl.size  <= udbf_pkg::SIZE_RESET;
      q.ctrl.baud  <= udbf_pkg::BAUD_RESET;
      q.rxd_s1     <= 1'b1;
      q.rxd_s2     <= 1'b1;
      q.txd        <= 1'b1;
      q.rx_st      <= udbf_pkg::RX_IDLE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rvalid  = q.rvalid;
  assign txd           = q.txd;
  assign txd_oe        = q.txd_oe;
  assign rx_pin_owned  = q.rx_own;
  assign udre_irq_req  = q.udre_irq;
  assign txc_irq_req   = q.txc_irq;

endmodule : udbf_top

`default_nettype wire

// ---- udbf_props.sv ----
// Port checks of the serial data buffer block.
// Assumes the top module's ports only; bound at the foot.
`timescale 1ns/1ns
`default_nettype none
module udbf_props (
  input wire logic aclk,          // Clock
  input wire logic aresetn,       // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_bvalid,  // Write response valid
  input wire logic s_axi_bready,  // Write response ready
  input wire logic txd,           // Serial output
  input wire logic txd_oe,        // Output pin owned
  input wire logic rx_pin_owned,  // Input pin owned
  input wire logic txc_irq_req,   // Complete request
  input wire logic txc_irq_ack    // Complete serviced
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  idle_high_a: assert property (!txd_oe |-> txd)
    else $error("released output not high");
  start_len_a: assert property ($fell(txd) |-> (!txd) [*8])
    else $error("start bit too short");
  oe_release_a: assert property ($fell(txd_oe) |-> $past(txd) && txd)
    else $error("output released mid frame");
  txc_rise_a: assert property ($rose(txc_irq_req) |-> txd)
    else $error("complete raised mid frame");
  txc_ack_a: assert property (txc_irq_ack |-> ##2 !txc_irq_req)
    else $error("complete not cleared by service");
  rx_own_a: assert property ($rose(rx_pin_owned) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("input pin taken without write");
endmodule : udbf_props
bind udbf_top udbf_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .txd(txd), .txd_oe(txd_oe), .rx_pin_owned(rx_pin_owned), .txc_irq_req(txc_irq_req),
  .txc_irq_ack(txc_irq_ack));
`default_nettype wire

// ---- udbf_peer.sv ----
// Remote serial peer: captures frames from txd, sends frames on rxd.
// Assumes 16 ticks per bit at divisor 1, so BIT clocks per bit.
`timescale 1ns/1ns
`default_nettype none
module udbf_peer #(parameter int BIT = 32) (
  input  wire logic aclk, // System clock
  input  wire logic txd,  // From device
  output var  logic rxd   // To device
);
  int         nb = 8;
  logic [9:0] got [$];
  logic [9:0] v;
  initial rxd = 1'b1;
  // Sample mid bit, LSB first, then parity if any, then stop
  always @(negedge txd) begin
    v = '0;
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(posedge aclk);
      v[i] = txd;
    end
    repeat (BIT) @(posedge aclk);
    v[9] = txd;
    got.push_back(v);
  end
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    rxd <= 1'b0;
    repeat (BIT) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (BIT) @(posedge aclk);
    end
    rxd <= stop;
    repeat (BIT) @(posedge aclk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge aclk);
  endtask : send
endmodule : udbf_peer
`default_nettype wire

// ---- udbf_top_tb.sv ----
// Self-checking bench of the serial data buffer block.
// Assumes udbf_peer on the pins and udbf_props bound in.
`timescale 1ns/1ns
`default_nettype none
module udbf_top_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic        arv = 1'b0, rry = 1'b0, ack = 1'b0, rxd;
  logic [7:0]  aa = 8'h00, d, d2;
  logic [31:0] wd = 32'h0, rv_d, rdt;
  logic [1:0]  br, rr, resp;
  logic        awr, wrd, bv, arr, rv, txd, oe, own, udre, txc;
  logic [9:0]  exp [$];
  int          failures = 0, tests_run = 0, seed = 32'h2471, n;
  initial forever #25 aclk = ~aclk;
  udbf_top u_udbf_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .rxd(rxd),
    .external_serial_clock(1'b0),
    .txd(txd), .txd_oe(oe), .rx_pin_owned(own), .udre_irq_req(udre), .txc_irq_req(txc),
    .txc_irq_ack(ack));
  udbf_peer u_peer (.aclk(aclk), .txd(txd), .rxd(rxd));
  task automatic final_report;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  // One write or one read; valids held until their own ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    aa <= a;
    wd <= v;
    {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
    n = 0;
    while ((w ? bv : rv) !== 1'b1 && n < 60) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (arr) arv <= 1'b0;
      n++;
    end
    rv_d = rdt;
    resp = w ? br : rr;
    {bry, rry} <= 2'b00;
    if (n >= 60) begin
      failures++;
      $display("[ERR] %0t bus wait timed out", $time);
      final_report();
    end
  endtask : bus
  // Waits for every expected frame, then compares in order
  task automatic tx_check;
    n = 0;
    while (u_peer.got.size() < exp.size() && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      $display("[ERR] %0t frame wait timed out", $time);
      final_report();
    end
    while (exp.size() > 0) chk(u_peer.got.pop_front(), exp.pop_front());
  endtask : tx_check
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    bus(0, 8'h04, 0); chk(rv_d, 32'h20);
    bus(0, 8'h14, 0); chk(resp, 2'h2);
    bus(1, 8'h10, 1); chk(resp, 2'h0);
    bus(1, 8'h0C, 32'h06);
    bus(1, 8'h08, 32'h78);
    // Request level lags the enable by one cycle
    @(posedge aclk);
    chk(udre, 1);
    chk(own, 1);
    repeat (2) begin
      d = $random(seed);
      exp.push_back({2'b10, d});
      bus(1, 8'h00, d);
    end
    bus(0, 8'h04, 0); chk(rv_d[5], 0);
    tx_check();
    for (n = 0; txc !== 1'b1 && n < 100; n++) @(posedge aclk);
    chk(txc, 1);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(txc, 0);
    for (int o = 0; o < 2; o++) begin
      bus(1, 8'h0C, 32'h26 | (o << 4));
      u_peer.nb = 9;
      d = $random(seed);
      exp.push_back({1'b1, ^d ^ o[0], d});
      bus(1, 8'h00, d);
      tx_check();
    end
    // Flag sets at the end of the stop bit, after the peer has sampled it
    for (n = 0; txc !== 1'b1 && n < 100; n++) @(posedge aclk);
    chk(txc, 1);
    bus(1, 8'h04, 32'h40);
    bus(0, 8'h04, 0); chk(rv_d[7:5], 3'b001);
    bus(1, 8'h0C, 32'h06);
    bus(1, 8'h08, 32'h7D);
    d = $random(seed);
    exp.push_back({2'b11, d});
    bus(1, 8'h00, d);
    bus(1, 8'h08, 32'h74);
    chk(oe, 1);
    tx_check();
    repeat (60) @(posedge aclk);
    chk(oe, 0);
    bus(1, 8'h08, 32'h10);
    d = $random(seed);
    // Upper bits set so the narrow frame later must mask leftovers
    d2 = $random(seed) | 8'hE0;
    u_peer.send({1'b0, d}, 8, 1'b1);
    u_peer.send({1'b0, d2}, 8, 1'b0);
    bus(0, 8'h04, 0); chk(rv_d[7], 1); chk(rv_d[4], 0);
    bus(0, 8'h00, 0); chk(rv_d, d);
    bus(0, 8'h04, 0); chk(rv_d[4], 1);
    bus(0, 8'h00, 0); chk(rv_d, d2);
    bus(0, 8'h04, 0); chk(rv_d[7], 0);
    bus(1, 8'h0C, 32'h00);
    u_peer.send(9'h0FF, 5, 1'b1);
    bus(0, 8'h00, 0); chk(rv_d, 32'h1F);
    final_report();
  end
endmodule : udbf_top_tb
`default_nettype wire
